/* File: verilog/cut_cfg.svh */
// constants for the core up/down timer
`ifndef CUT_CFG_SVH
`define CUT_CFG_SVH
`define CUT_WIDTH 16
`define CUT_MODE_TIMER 3'h0
`define CUT_MODE_COUNTER 3'h1
`define CUT_MODE_GATE_LOW 3'h2
`define CUT_MODE_GATE_HIGH 3'h3
`define CUT_EDGE_NONE 3'h0
`define CUT_EDGE_RISE 3'h1
`define CUT_EDGE_FALL 3'h2
`define CUT_EDGE_BOTH 3'h3
`define CUT_PRE_WIDTH 11
`define CUT_BASE_SHIFT 3
`define CUT_FAST_SHIFT 2
`define CUT_ALL_ONES 16'hffff
`define CUT_ZERO 16'h0000
`define CUT_PRE_ZERO 11'h000
`endif

/* File: verilog/cut_pkg.sv */
// types for the core up/down timer
package cut_pkg;
	typedef enum logic [2:0] {
		cut_timer,
		cut_counter,
		cut_gate_low,
		cut_gate_high,
		cut_unused_4,
		cut_unused_5,
		cut_incr_6,
		cut_incr_7
	} cut_mode_t;
endpackage : cut_pkg

/* File: verilog/cut_core_timer.sv */
// core up/down timer with toggle latch and overflow line
`include "cut_cfg.svh"
// Behaviour
// - counts only while run bit set
// - gated mode needs run and active gate
// - run bit also drives remote aux runs
// - software direction: invert bit picks up/down
// - pin direction: equal to invert counts up
// - direction change accepted any time
// - wrap toggles the toggle latch
// - software sets or clears toggle latch
// - toggle pin shows latch when enabled
// - latch routed internally to aux timers
// - wrap pulses the internal overflow line
// - timer mode: prescale 8 (4 with fast prescale bit) times 2^select
// - gated modes low or high active
// - mode bit 0 picks gate level
// - gate edges raise no interrupt
// - counter mode counts pin transitions
// - select field picks count edge
// - count register sixteen bits wide
// - cpu count write beats hardware update
module cut_core_timer (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_core_run_bit,
	input wire logic [2:0] i_mode_select_field,
	input wire logic [2:0] i_input_select_field,
	input wire logic i_fast_prescale_bit,
	input wire logic i_direction_invert_bit,
	input wire logic i_external_direction_enable,
	input wire logic i_toggle_output_enable,
	input wire logic i_aux_a_remote_run_enable,
	input wire logic i_aux_b_remote_run_enable,
	input wire logic i_latch_write,
	input wire logic i_latch_write_value,
	input wire logic i_count_write,
	input wire logic [`CUT_WIDTH-1:0] i_count_write_value,
	input wire logic i_gate_count_input_pin,
	input wire logic i_direction_input_pin,
	output logic [`CUT_WIDTH-1:0] o_core_timer,
	output logic o_count_down,
	output logic o_overflow_toggle_latch,
	output logic o_toggle_output_pin,
	output logic o_overflow_pulse_line,
	output logic o_aux_a_remote_run,
	output logic o_aux_b_remote_run
);
	logic [1:0] gate_sync_q;
	logic [1:0] dir_sync_q;
	logic gate_prev_q;
	logic [`CUT_PRE_WIDTH-1:0] pre_q;
	logic [`CUT_PRE_WIDTH-1:0] pre_d;
	logic [`CUT_WIDTH-1:0] count_q;
	logic [`CUT_WIDTH-1:0] count_d;
	logic down_q;
	logic down_d;
	logic latch_q;
	logic latch_d;
	logic tout_q;
	logic tout_d;
	logic ofl_q;
	logic ofl_d;
	logic run_a_q;
	logic run_a_d;
	logic run_b_q;
	logic run_b_d;
	logic gate_now;
	logic down_now;
	logic pre_tick;
	logic step;
	logic wrap;
	logic [4:0] shift;
	logic [`CUT_PRE_WIDTH-1:0] pre_last;
	cut_pkg::cut_mode_t mode;

	assign gate_now = gate_sync_q[1];
	assign mode = cut_pkg::cut_mode_t'(i_mode_select_field);

	always_comb begin
		// direction from bit or synchronised pin
		if (i_external_direction_enable) begin
			down_now = dir_sync_q[1] != i_direction_invert_bit;
		end else begin
			down_now = i_direction_invert_bit;
		end
		// divisor 8 or 4 times 2^select
		shift = {2'h0, i_input_select_field} +
			(i_fast_prescale_bit ? 5'(`CUT_FAST_SHIFT) : 5'(`CUT_BASE_SHIFT));
		pre_last = `CUT_PRE_WIDTH'((`CUT_PRE_WIDTH+1)'(1) << shift) - `CUT_PRE_WIDTH'(1);
		pre_tick = pre_q >= pre_last;
		step = 1'b0;
		pre_d = pre_q;
		unique case (mode)
			cut_pkg::cut_timer, cut_pkg::cut_gate_low, cut_pkg::cut_gate_high: begin
				if (i_core_run_bit && (mode == cut_pkg::cut_timer ||
					gate_now == i_mode_select_field[0])) begin
					pre_d = pre_tick ? `CUT_PRE_ZERO : pre_q + `CUT_PRE_WIDTH'(1);
					step = pre_tick;
				end
			end
			cut_pkg::cut_counter: begin
				// selected edges of the synchronised pin
				unique case (i_input_select_field)
					`CUT_EDGE_RISE: step = gate_now && !gate_prev_q;
					`CUT_EDGE_FALL: step = !gate_now && gate_prev_q;
					`CUT_EDGE_BOTH: step = gate_now != gate_prev_q;
					default: step = 1'b0;
				endcase
				step = step && i_core_run_bit;
			end
			default: step = 1'b0;
		endcase
		// wrap at the ends of the range
		wrap = step && (down_now ? count_q == `CUT_ZERO : count_q == `CUT_ALL_ONES);
		count_d = count_q;
		if (i_count_write) begin
			count_d = i_count_write_value;
		end else if (step) begin
			count_d = down_now ? count_q - `CUT_WIDTH'(1) : count_q + `CUT_WIDTH'(1);
		end
		down_d = down_now;
		// hardware toggle wins over software write
		latch_d = latch_q;
		if (wrap) begin
			latch_d = !latch_q;
		end else if (i_latch_write) begin
			latch_d = i_latch_write_value;
		end
		tout_d = i_toggle_output_enable && latch_d;
		ofl_d = wrap;
		run_a_d = i_aux_a_remote_run_enable && i_core_run_bit;
		run_b_d = i_aux_b_remote_run_enable && i_core_run_bit;
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			gate_sync_q <= 2'h0;
			dir_sync_q <= 2'h0;
			gate_prev_q <= 1'b0;
			pre_q <= `CUT_PRE_ZERO;
			count_q <= `CUT_ZERO;
			down_q <= 1'b0;
			latch_q <= 1'b0;
			tout_q <= 1'b0;
			ofl_q <= 1'b0;
			run_a_q <= 1'b0;
			run_b_q <= 1'b0;
		end else begin
			gate_sync_q <= {gate_sync_q[0], i_gate_count_input_pin};
			dir_sync_q <= {dir_sync_q[0], i_direction_input_pin};
			gate_prev_q <= gate_now;
			pre_q <= pre_d;
			count_q <= count_d;
			down_q <= down_d;
			latch_q <= latch_d;
			tout_q <= tout_d;
			ofl_q <= ofl_d;
			run_a_q <= run_a_d;
			run_b_q <= run_b_d;
		end
	end

	// latch itself is the internal route to aux timers
	assign o_core_timer = count_q;
	assign o_count_down = down_q;
	assign o_overflow_toggle_latch = latch_q;
	assign o_toggle_output_pin = tout_q;
	assign o_overflow_pulse_line = ofl_q;
	assign o_aux_a_remote_run = run_a_q;
	assign o_aux_b_remote_run = run_b_q;
	// no interrupt output exists, so gate edges raise none

	a_stop_holds: assert property (@(posedge i_clock) disable iff (i_reset)
		!i_core_run_bit && !i_count_write |=> $stable(o_core_timer))
		else $error("count moved while stopped");

	a_gate_blocks: assert property (@(posedge i_clock) disable iff (i_reset)
		(mode == cut_pkg::cut_gate_high) && !gate_now && !i_count_write
		|=> $stable(o_core_timer))
		else $error("count moved with gate closed");

	a_remote_run: assert property (@(posedge i_clock) disable iff (i_reset)
		##1 o_aux_a_remote_run == $past(i_aux_a_remote_run_enable && i_core_run_bit))
		else $error("remote run mismatch");

	a_soft_dir: assert property (@(posedge i_clock) disable iff (i_reset)
		!i_external_direction_enable |=> o_count_down == $past(i_direction_invert_bit))
		else $error("software direction wrong");

	a_pin_dir: assert property (@(posedge i_clock) disable iff (i_reset)
		i_external_direction_enable
		|=> o_count_down == ($past(dir_sync_q[1]) != $past(i_direction_invert_bit)))
		else $error("pin direction wrong");

	a_wrap_toggles: assert property (@(posedge i_clock) disable iff (i_reset)
		o_overflow_pulse_line |-> o_overflow_toggle_latch != $past(o_overflow_toggle_latch))
		else $error("wrap without toggle");

	a_pin_follows: assert property (@(posedge i_clock) disable iff (i_reset)
		##1 o_toggle_output_pin == ($past(i_toggle_output_enable) && o_overflow_toggle_latch))
		else $error("toggle pin mismatch");

	a_cpu_wins: assert property (@(posedge i_clock) disable iff (i_reset)
		i_count_write |=> o_core_timer == $past(i_count_write_value))
		else $error("cpu write lost");

	sequence s_up_wrap;
		o_core_timer == `CUT_ALL_ONES && !o_count_down && !i_count_write && step && !down_now;
	endsequence
	a_up_wraps: assert property (@(posedge i_clock) disable iff (i_reset)
		s_up_wrap |=> o_core_timer == `CUT_ZERO && o_overflow_pulse_line)
		else $error("up wrap wrong");
endmodule : cut_core_timer

/* File: verification/cut_pin_model.sv */
// model of the gate, count and direction pins
module cut_pin_model (
	input wire logic i_clock,
	output logic o_gate_count_input_pin,
	output logic o_direction_input_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_gate_count_input_pin = 1'h0;
		o_direction_input_pin = 1'h0;
	end
	task automatic hold();
		repeat (5) @(posedge i_clock);
	endtask : hold
	task automatic set_gate(input logic v);
		@(posedge i_clock);
		o_gate_count_input_pin <= v;
		hold();
	endtask : set_gate
	task automatic set_dir(input logic v);
		@(posedge i_clock);
		o_direction_input_pin <= v;
		hold();
	endtask : set_dir
	task automatic toggle(input int n);
		repeat (n) set_gate(~o_gate_count_input_pin);
	endtask : toggle
endmodule : cut_pin_model

/* File: verification/cut_core_timer_tb.sv */
// self-checking bench for the core up/down timer
module cut_core_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'h0, rst = 1'h1, run = 1'h0, fast = 1'h0, inv = 1'h0, ext = 1'h0;
	logic oe = 1'h0, ra = 1'h0, rb = 1'h0, lw = 1'h0, lv = 1'h0, cw = 1'h0;
	logic [2:0] mode = 3'h0, sel = 3'h0;
	logic [15:0] cv = 16'h0000, cnt, c0;
	logic down, otl, pin, ofl, aa, ab, gp, dp;
	int errors = 0, n_tests = 0, k;
	cut_core_timer DUT (.i_clock(clk), .i_reset(rst), .i_core_run_bit(run),
		.i_mode_select_field(mode), .i_input_select_field(sel), .i_fast_prescale_bit(fast),
		.i_direction_invert_bit(inv), .i_external_direction_enable(ext),
		.i_toggle_output_enable(oe), .i_aux_a_remote_run_enable(ra),
		.i_aux_b_remote_run_enable(rb), .i_latch_write(lw), .i_latch_write_value(lv),
		.i_count_write(cw), .i_count_write_value(cv), .i_gate_count_input_pin(gp),
		.i_direction_input_pin(dp), .o_core_timer(cnt), .o_count_down(down),
		.o_overflow_toggle_latch(otl), .o_toggle_output_pin(pin),
		.o_overflow_pulse_line(ofl), .o_aux_a_remote_run(aa), .o_aux_b_remote_run(ab));
	cut_pin_model pins (.i_clock(clk), .o_gate_count_input_pin(gp),
		.o_direction_input_pin(dp));
	initial forever #2 clk = ~clk;
	task automatic summarize();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", s, e, g);
			errors++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [15:0] v);
		@(posedge clk);
		cw <= 1'h1;
		cv <= v;
		cyc(1);
		cw <= 1'h0;
		cyc(1);
	endtask : wr
	task automatic latch(input logic v);
		@(posedge clk);
		lw <= 1'h1;
		lv <= v;
		cyc(1);
		lw <= 1'h0;
		cyc(1);
	endtask : latch
	task automatic chg(output int n);
		c0 = cnt;
		n = 0;
		while (cnt === c0) begin
			@(posedge clk);
			n++;
			if (n > 3000) begin
				errors++;
				summarize();
			end
		end
	endtask : chg
	task automatic per(input int e, input string s);
		int n;
		chg(n);
		chg(n);
		chk(s, 16'(e), 16'(n));
	endtask : per
	initial begin
		cyc(2);
		rst <= 1'h0;
		cyc(2);
		chk("reset count", 16'h0000, cnt);
		run <= 1'h1;
		per(8, "base period");
		fast <= 1'h1;
		per(4, "fast period");
		fast <= 1'h0;
		sel <= 3'h1;
		per(16, "select 1 period");
		sel <= 3'h0;
		inv <= 1'h1;
		chg(k);
		chg(k);
		chk("count down", 16'(c0 - 16'h0001), cnt);
		wr(16'h1234);
		chk("write priority", 16'h1234, cnt);
		run <= 1'h0;
		cyc(3);
		c0 = cnt;
		cyc(40);
		chk("stopped", c0, cnt);
		for (k = 0; k < 8; k++) begin
			{run, ra, rb} <= k[2:0];
			cyc(3);
			chk("aux a run", 16'(k[2] & k[1]), 16'(aa));
			chk("aux b run", 16'(k[2] & k[0]), 16'(ab));
		end
		for (k = 0; k < 8; k++) begin
			ext <= k[2];
			inv <= k[0];
			pins.set_dir(k[1]);
			chk("direction", 16'(k[2] ? k[1] ^ k[0] : k[0]), 16'(down));
		end
		ext <= 1'h0;
		inv <= 1'h0;
		oe <= 1'h1;
		wr(16'hffff);
		chg(k);
		chk("wrap up", 16'h0000, cnt);
		chk("pulse", 16'h0001, 16'(ofl));
		chk("latch", 16'h0001, 16'(otl));
		cyc(2);
		chk("toggle pin", 16'h0001, 16'(pin));
		inv <= 1'h1;
		chg(k);
		chk("wrap down", 16'hffff, cnt);
		chk("latch back", 16'h0000, 16'(otl));
		run <= 1'h0;
		latch(1'h1);
		chk("latch set", 16'h0001, 16'(otl));
		latch(1'h0);
		chk("latch clear", 16'h0000, 16'(otl));
		mode <= 3'h2;
		run <= 1'h1;
		pins.set_gate(1'h1);
		c0 = cnt;
		cyc(40);
		chk("gate closed", c0, cnt);
		pins.set_gate(1'h0);
		per(8, "gate open");
		mode <= 3'h3;
		cyc(3);
		c0 = cnt;
		cyc(40);
		chk("high gate", c0, cnt);
		mode <= 3'h1;
		inv <= 1'h0;
		for (k = 0; k < 5; k++) begin
			sel <= k[2:0];
			cyc(3);
			c0 = cnt;
			pins.toggle(4);
			cyc(4);
			chk("edges", 16'(c0 + (k == 3 ? 4 : (k == 1 || k == 2) ? 2 : 0)), cnt);
		end
		summarize();
	end
endmodule : cut_core_timer_tb
